/* hw/jls_pkg.sv */
`default_nettype none
package jls_pkg;
   // ==========================================================
   // constants
   localparam int          LMFC_PERIOD_CYC = 32;      // frames*K in device clocks
   localparam int          ILAS_MF_COUNT   = 4;       // multiframes of alignment sequence
   localparam int          LANES           = 4;
   localparam int          LANE_W          = 32;      // four octets per lane word
   localparam int          SKEW_DEPTH      = 8;
   localparam logic [7:0]  K_CHAR          = 8'hBC;   // K28.5 octet
   localparam logic [7:0]  R_CHAR          = 8'h1C;   // multiframe start marker
   localparam logic [7:0]  Q_CHAR          = 8'h9C;   // config follows marker
   localparam logic [3:0]  MCS_RESET_VAL   = 4'h0;
   localparam int          ST_LINK_SYSREF  = 0;
   localparam int          ST_DIG_CLOCKS   = 1;
   localparam int          ST_PLL_MOD      = 2;
   localparam int          ST_DEVCLK_DIV   = 3;
   localparam logic [1:0]  PULSE_SYNC_LAST = 2'd2;    // pulses counted for clocks sync

   // ==========================================================
   // types
   typedef enum {FR_CGS, FR_WAIT_REL, FR_ILAS, FR_DATA} jls_fr_state_t;
   typedef enum {DF_CGS, DF_RELEASE, DF_ALIGN, DF_DATA} jls_df_state_t;

   typedef struct packed {
      logic [LANES*LANE_W-1:0] data;
      logic [LANES-1:0]        is_k;     // whole word holds K chars
      logic [LANES-1:0]        mf_start; // lane word opens a multiframe
   } jls_lanes_t;

   typedef struct packed {
      logic [7:0] lanes_m1;
      logic [7:0] frames_m1;
      logic       scramble;
   } jls_cfg_t;
endpackage
`default_nettype wire

/* hw/jls_lmfc.sv */
`default_nettype none
// ==========================================================
// local multiframe counter with SYSREF alignment
module jls_lmfc #(
   parameter int PERIOD = jls_pkg::LMFC_PERIOD_CYC
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic sysref,       // link-forwarded pulse
   input  wire logic realign_en,   // allow realign after first
   output logic      boundary
);
   import jls_pkg::*;
   typedef struct packed {
      logic [7:0] cnt;
      logic       aligned;
   } jls_lmfc_st_t;
   jls_lmfc_st_t s_r, s_nxt;

   // wrap counter; later pulses realign only when allowed
   always_comb begin
      s_nxt = s_r;
      if (sysref && (!s_r.aligned || realign_en)) begin
         s_nxt.cnt     = 8'h00;
         s_nxt.aligned = 1'b1;
      end else if (s_r.cnt == 8'(PERIOD - 1)) begin
         s_nxt.cnt = 8'h00;
      end else begin
         s_nxt.cnt = s_r.cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign boundary = (s_r.cnt == 8'(PERIOD - 1));
endmodule
`default_nettype wire

/* hw/jls_mcs.sv */
`default_nettype none
// ==========================================================
// multichip sync sequencer
module jls_mcs (
   input  wire logic  mclk,
   input  wire logic  rst,
   input  wire logic  arm,
   input  wire logic  sysref,
   output logic       scaler_rst,    // one-cycle reset pulses
   output logic       divider_rst,
   output logic       link_sysref,
   output logic [3:0] status
);
   import jls_pkg::*;
   typedef struct packed {
      logic [1:0] pulses;  // saturates at three
      logic [3:0] sticky;
      logic       done;    // three pulses taken
   } jls_mcs_st_t;
   jls_mcs_st_t s_r, s_nxt;
   logic        take;

   always_comb begin
      s_nxt = s_r;
      take  = arm && sysref && !s_r.done;
      if (take) begin
         s_nxt.pulses = s_r.pulses + 2'd1;
         if (s_r.pulses == 2'd0) begin
            s_nxt.sticky[ST_DEVCLK_DIV] = 1'b1;
         end else if (s_r.pulses == 2'd1) begin
            s_nxt.sticky[ST_DIG_CLOCKS] = 1'b1;
         end else begin
            s_nxt.sticky[ST_LINK_SYSREF] = 1'b1;
            s_nxt.done = 1'b1;
         end
      end
      // modulator bit fixed low, integer PLL
      s_nxt.sticky[ST_PLL_MOD] = 1'b0;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // pulses one and two to clocks, rest to link
   assign scaler_rst  = take && (s_r.pulses == 2'd0);
   assign divider_rst = take && (s_r.pulses == 2'd1);
   assign link_sysref = sysref && (s_r.pulses == PULSE_SYNC_LAST || s_r.done);
   // readback only when disarmed
   assign status      = arm ? MCS_RESET_VAL : s_r.sticky;
endmodule
`default_nettype wire

/* hw/jls_link_top.sv */
`default_nettype none
// ==========================================================
// link establishment top: framer, deframer, multichip sync
module jls_link_top (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   // sysref and multichip sync control
   input  wire logic                 sysref_pulse_input,
   input  wire logic                 multichip_sync_arm,
   input  wire logic                 realign_on_later_sysref,
   output logic [3:0]                multichip_sync_result_word,
   output logic                      scaler_reset,
   output logic                      divider_reset,
   // sync pin mode selects
   input  wire logic [1:0]           rx_sync_pin_signalling_select,
   input  wire logic [1:0]           tx_sync_pin_signalling_select,
   input  wire logic                 rx_link_sync_input_p,
   input  wire logic                 rx_link_sync_input_m,
   output logic                      tx_link_sync_output_p,
   output logic                      tx_link_sync_output_m,
   output logic                      tx_link_sync_output_m_oe_n,
   // framer side
   input  wire logic [jls_pkg::LANES*jls_pkg::LANE_W-1:0] adc_samples,
   input  wire logic                 framer_scramble,
   output jls_pkg::jls_lanes_t       fr_lanes,
   output logic                      fr_sending_data,
   // deframer side
   input  wire jls_pkg::jls_lanes_t  df_lanes,
   input  wire logic                 df_lanes_locked,
   input  wire jls_pkg::jls_cfg_t    df_cfg_expected,
   input  wire jls_pkg::jls_cfg_t    df_cfg_received,
   input  wire logic                 df_cfg_valid,
   output logic [jls_pkg::LANES*jls_pkg::LANE_W-1:0] dac_samples,
   output logic                      dac_valid,
   output logic                      df_cfg_mismatch,
   output logic                      deframer_sync_request_out_n
);
   import jls_pkg::*;

   // ==========================================================
   // helpers
   // replicate the K octet across a lane word
   function automatic logic [LANE_W-1:0] k_word();
      return {(LANE_W/8){K_CHAR}};
   endfunction

   // ==========================================================
   // sync pin decode
   logic framer_sync_request_in_n;  // resolved incoming request
   always_comb begin
      // zero picks differential: need the pair to agree
      if (rx_sync_pin_signalling_select == 2'd0) begin
         framer_sync_request_in_n = rx_link_sync_input_p & ~rx_link_sync_input_m;
      end else begin
         framer_sync_request_in_n = rx_link_sync_input_p;
      end
   end

   // ==========================================================
   // multichip sync and LMFC
   logic link_sysref;
   logic scaler_rst_w, divider_rst_w;
   logic [3:0] mcs_status_w;
   logic fr_bnd, df_bnd;

   jls_mcs u_mcs (
      .mclk        (mclk),
      .rst         (rst),
      .arm         (multichip_sync_arm),
      .sysref      (sysref_pulse_input),   // synchronous to mclk by contract
      .scaler_rst  (scaler_rst_w),
      .divider_rst (divider_rst_w),
      .link_sysref (link_sysref),
      .status      (mcs_status_w)
   );

   jls_lmfc u_fr_lmfc (
      .mclk       (mclk),
      .rst        (rst),
      .sysref     (link_sysref),
      .realign_en (realign_on_later_sysref),
      .boundary   (fr_bnd)
   );

   jls_lmfc u_df_lmfc (
      .mclk       (mclk),
      .rst        (rst),
      .sysref     (link_sysref),
      .realign_en (realign_on_later_sysref),
      .boundary   (df_bnd)
   );

   // ==========================================================
   // module state
   typedef struct packed {
      jls_fr_state_t fr;
      jls_df_state_t df;
      logic          fr_sysref_seen;
      logic [3:0]    fr_mf;
      jls_lanes_t    fr_out;
      logic          fr_data;
      logic [3:0]    df_ilas_mf;
      logic          df_sync_n;
      logic          df_cfg_ok;
      logic          mismatch;
      logic [LANES-1:0] lane_seen;  // lane start seen
      logic [LANES*LANE_W-1:0] dac;
      logic          dac_v;
      logic [3:0]    mcs;
      logic          sc_rst;
      logic          dv_rst;
      logic          sync_out;
      logic          sync_m;    // minus pin level
      logic          m_oe_n;    // minus pin enable, low drives
   } jls_top_st_t;
   jls_top_st_t s_r, s_nxt;

   // per-lane skew buffers, flops indexed by depth
   logic [LANE_W-1:0] skew_r   [LANES][SKEW_DEPTH];
   logic [2:0]        wptr_r   [LANES];
   logic [2:0]        rptr_r   [LANES];

   // ==========================================================
   // next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.sc_rst = scaler_rst_w;
      s_nxt.dv_rst = divider_rst_w;
      s_nxt.mcs    = mcs_status_w;

      // ----- framer -----
      case (s_r.fr)
         FR_CGS: begin
            s_nxt.fr_data = 1'b0;
            if (link_sysref) begin
               s_nxt.fr_sysref_seen = 1'b1;
            end
            if ((s_r.fr_sysref_seen || link_sysref) && framer_sync_request_in_n) begin
               s_nxt.fr = FR_WAIT_REL;
            end
         end
         FR_WAIT_REL: begin
            if (!framer_sync_request_in_n) begin
               s_nxt.fr = FR_CGS;
            end else if (fr_bnd) begin
               s_nxt.fr    = FR_ILAS;
               s_nxt.fr_mf = 4'h0;
            end
         end
         FR_ILAS: begin
            if (!framer_sync_request_in_n) begin
               s_nxt.fr = FR_CGS;
            end else if (fr_bnd) begin
               if (s_r.fr_mf == 4'(ILAS_MF_COUNT - 1)) begin
                  s_nxt.fr = FR_DATA;
               end else begin
                  s_nxt.fr_mf = s_r.fr_mf + 4'h1;
               end
            end
         end
         FR_DATA: begin
            if (!framer_sync_request_in_n) begin
               s_nxt.fr = FR_CGS;
            end
         end
         default: s_nxt.fr = FR_CGS;
      endcase

      // framer lane output; ILAS never scrambled
      s_nxt.fr_out = '0;
      case (s_nxt.fr)
         FR_ILAS: begin
            for (int i = 0; i < LANES; i++) begin
               s_nxt.fr_out.data[i*LANE_W +: LANE_W] = {R_CHAR, Q_CHAR, 16'h0000};
               s_nxt.fr_out.mf_start[i] = 1'b1;
            end
         end
         FR_DATA: begin
            // scrambler itself sits in the serializer lane path
            s_nxt.fr_out.data = adc_samples;
            s_nxt.fr_data     = 1'b1;
         end
         default: begin
            for (int i = 0; i < LANES; i++) begin
               s_nxt.fr_out.data[i*LANE_W +: LANE_W] = k_word();
               s_nxt.fr_out.is_k[i] = 1'b1;
            end
         end
      endcase

      // ----- deframer -----
      s_nxt.dac_v = 1'b0;
      case (s_r.df)
         DF_CGS: begin
            s_nxt.df_sync_n = 1'b0;
            s_nxt.lane_seen = '0;
            s_nxt.df_cfg_ok = 1'b0;
            if (df_lanes_locked && (&df_lanes.is_k)) begin
               s_nxt.df = DF_RELEASE;
            end
         end
         DF_RELEASE: begin
            if (!df_lanes_locked) begin
               s_nxt.df = DF_CGS;
            end else if (df_bnd) begin
               s_nxt.df_sync_n = 1'b1;
               s_nxt.df        = DF_ALIGN;
            end
         end
         DF_ALIGN: begin
            s_nxt.lane_seen = s_r.lane_seen | df_lanes.mf_start;
            if (df_cfg_valid) begin
               s_nxt.df_cfg_ok = (df_cfg_received == df_cfg_expected);
            end
            if (!df_lanes_locked) begin
               s_nxt.df = DF_CGS;
            end else if (df_bnd && (&s_r.lane_seen) && s_r.df_cfg_ok) begin
               s_nxt.df = DF_DATA;
            end
         end
         DF_DATA: begin
            s_nxt.dac_v = 1'b1;
            for (int i = 0; i < LANES; i++) begin
               s_nxt.dac[i*LANE_W +: LANE_W] = skew_r[i][rptr_r[i]];
            end
            if (!df_lanes_locked) begin
               s_nxt.df = DF_CGS;
            end
         end
         default: s_nxt.df = DF_CGS;
      endcase
      if (s_nxt.df == DF_CGS) begin
         s_nxt.df_sync_n = 1'b0;
      end
      s_nxt.sync_out = s_nxt.df_sync_n;
      s_nxt.sync_m   = ~s_nxt.df_sync_n;
      s_nxt.m_oe_n   = (tx_sync_pin_signalling_select != 2'd0);
      // mismatch tracks every config strobe
      if (df_cfg_valid) begin
         s_nxt.mismatch = (df_cfg_received != df_cfg_expected);
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r    <= '0;
         s_r.fr <= FR_CGS;
         s_r.df <= DF_CGS;
         s_r.sync_m <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // skew buffers: write from multiframe start, read pointer held at zero until the cycle whose next state is data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < LANES; i++) begin
            wptr_r[i] <= 3'd0;
            rptr_r[i] <= 3'd0;
            for (int j = 0; j < SKEW_DEPTH; j++) begin
               skew_r[i][j] <= '0;
            end
         end
      end else begin
         for (int i = 0; i < LANES; i++) begin
            if (s_r.df == DF_ALIGN && !s_r.lane_seen[i] && !df_lanes.mf_start[i]) begin
               wptr_r[i] <= 3'd0;                     // hold until lane start
            end else if (s_r.df == DF_ALIGN || s_r.df == DF_DATA) begin
               skew_r[i][wptr_r[i]] <= df_lanes.data[i*LANE_W +: LANE_W];
               wptr_r[i] <= wptr_r[i] + 3'd1;
            end
            // lanes read from one boundary
            if (s_r.df == DF_DATA || s_nxt.df == DF_DATA) begin
               rptr_r[i] <= rptr_r[i] + 3'd1;
            end else begin
               rptr_r[i] <= 3'd0;
            end
         end
      end
   end

   // ==========================================================
   // outputs, all from flops
   assign fr_lanes                    = s_r.fr_out;
   assign fr_sending_data             = s_r.fr_data;
   assign dac_samples                 = s_r.dac;
   assign dac_valid                   = s_r.dac_v;
   assign df_cfg_mismatch             = s_r.mismatch;
   assign multichip_sync_result_word  = s_r.mcs;
   assign scaler_reset                = s_r.sc_rst;
   assign divider_reset               = s_r.dv_rst;
   assign deframer_sync_request_out_n = s_r.sync_out;
   // p carries the level; m is complement or released
   assign tx_link_sync_output_p       = s_r.sync_out;
   assign tx_link_sync_output_m       = s_r.sync_m;
   assign tx_link_sync_output_m_oe_n  = s_r.m_oe_n;
endmodule
`default_nettype wire

/* sim/jls_link_monitor.sv */
`default_nettype none
// ==========================================================
// port checker for the link top
module jls_link_monitor (
   input wire logic                mclk,
   input wire logic                rst,
   input wire logic                sysref_pulse_input,
   input wire logic                multichip_sync_arm,
   input wire logic [3:0]          multichip_sync_result_word,
   input wire logic                scaler_reset,
   input wire logic                divider_reset,
   input wire logic [1:0]          rx_sync_pin_signalling_select,
   input wire logic [1:0]          tx_sync_pin_signalling_select,
   input wire logic                rx_link_sync_input_p,
   input wire logic                rx_link_sync_input_m,
   input wire logic                tx_link_sync_output_m_oe_n,
   input wire jls_pkg::jls_lanes_t fr_lanes,
   input wire logic                fr_sending_data,
   input wire logic                df_lanes_locked,
   input wire logic                dac_valid,
   input wire logic                deframer_sync_request_out_n
);
   import jls_pkg::*;
   typedef struct packed {
      logic [1:0] sc;  // scaler strobes, saturating
      logic [1:0] dv;  // divider strobes, saturating
   } jls_mon_t;
   jls_mon_t st_r;
   jls_mon_t st_nxt;
   logic     req_n;   // framer request at the pins
   logic     txd;     // tx pin select is differential
   // ==========================================================
   // strobe counters for order checks
   always_comb begin
      st_nxt = st_r;
      if (scaler_reset && st_r.sc != 2'h3) begin
         st_nxt.sc = st_r.sc + 2'h1;
      end
      if (divider_reset && st_r.dv != 2'h3) begin
         st_nxt.dv = st_r.dv + 2'h1;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   // differential releases only with p high and m low
   assign req_n = (rx_sync_pin_signalling_select == 2'h0) ? (rx_link_sync_input_p & ~rx_link_sync_input_m)
                                                          : rx_link_sync_input_p;
   assign txd = tx_sync_pin_signalling_select == 2'h0;
   // ==========================================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_sync_out_reset: assert property ($fell(rst) |-> !deframer_sync_request_out_n)
      else $error("request high after reset");
   a_armed_reads_zero: assert property (multichip_sync_arm && $past(multichip_sync_arm) |-> multichip_sync_result_word == 4'h0)
      else $error("status shown armed");
   a_scaler_first: assert property (scaler_reset |-> $past(sysref_pulse_input) && $past(multichip_sync_arm) && st_r.sc == 2'h0)
      else $error("scaler order");
   a_divider_second: assert property (divider_reset |-> $past(sysref_pulse_input) && st_r.sc == 2'h1 && st_r.dv == 2'h0)
      else $error("divider order");
   a_status_bits: assert property (!multichip_sync_arm && !$past(multichip_sync_arm) |-> multichip_sync_result_word[3] == (st_r.sc != 2'h0) && multichip_sync_result_word[1] == (st_r.dv != 2'h0))
      else $error("status vs strobes");
   a_mod_bit_zero: assert property (!multichip_sync_result_word[ST_PLL_MOD])
      else $error("modulator set");
   a_cgs_on_req: assert property (!req_n [*3] |-> &fr_lanes.is_k)
      else $error("no K under request");
   a_no_data_req: assert property (!req_n [*3] |-> !fr_sending_data)
      else $error("data under request");
   a_sync_needs_lock: assert property ($rose(deframer_sync_request_out_n) |-> $past(df_lanes_locked))
      else $error("release without lock");
   a_dac_after_sync: assert property ($rose(dac_valid) |-> deframer_sync_request_out_n)
      else $error("dac before release");
   a_oe_diff: assert property (!$past(rst) && txd && $past(txd) |-> !tx_link_sync_output_m_oe_n)
      else $error("m pin idle in diff");
   a_oe_single: assert property (!$past(rst) && !txd && !$past(txd) |-> tx_link_sync_output_m_oe_n)
      else $error("m pin driven single");
   c_divider: cover property (divider_reset);
   c_data: cover property ($rose(fr_sending_data));
   c_dac: cover property ($rose(dac_valid));
endmodule
bind jls_link_top jls_link_monitor u_mon (
   .mclk(mclk), .rst(rst), .sysref_pulse_input(sysref_pulse_input), .multichip_sync_arm(multichip_sync_arm),
   .multichip_sync_result_word(multichip_sync_result_word), .scaler_reset(scaler_reset),
   .divider_reset(divider_reset), .rx_sync_pin_signalling_select(rx_sync_pin_signalling_select),
   .tx_sync_pin_signalling_select(tx_sync_pin_signalling_select), .rx_link_sync_input_p(rx_link_sync_input_p),
   .rx_link_sync_input_m(rx_link_sync_input_m), .tx_link_sync_output_m_oe_n(tx_link_sync_output_m_oe_n),
   .fr_lanes(fr_lanes), .fr_sending_data(fr_sending_data), .df_lanes_locked(df_lanes_locked),
   .dac_valid(dac_valid), .deframer_sync_request_out_n(deframer_sync_request_out_n)
);
`default_nettype wire

/* sim/jls_bbp_model.sv */
`default_nettype none
// ==========================================================
// far-end transmitter model
module jls_bbp_model #(
   parameter logic [127:0] USER = 128'h0  // constant payload per lane
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              sync_n,    // deframer request, active low
   input  wire logic              fr_req_n,  // wanted framer request
   input  wire logic [1:0]        rx_sel,    // pin mode of that request
   input  wire logic [7:0]        lag,       // ILAS start delay
   input  wire jls_pkg::jls_cfg_t cfg_send,
   input  wire logic              cfg_kick,  // extra config strobe
   output jls_pkg::jls_lanes_t    df_lanes,
   output jls_pkg::jls_cfg_t      df_cfg_received,
   output logic                   df_cfg_valid,
   output logic                   rx_p,
   output logic                   rx_m
);
   import jls_pkg::*;
   localparam int ILAS_CYC = ILAS_MF_COUNT * LMFC_PERIOD_CYC;
   int cnt;  // cycles since release, stops once payload starts
   int ph;   // cycles into ILAS
   assign ph = cnt - int'(lag);
   // request rides p; single-ended leaves m to its pull-down
   assign rx_p = fr_req_n;
   assign rx_m = (rx_sel == 2'h0) ? ~fr_req_n : 1'b0;
   // ==========================================================
   // lane stream
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         df_lanes <= '0;
         df_cfg_valid <= 1'b0;
         df_cfg_received <= '0;
      end else begin
         df_cfg_valid <= cfg_kick;
         df_cfg_received <= cfg_send;
         df_lanes.is_k <= '0;
         df_lanes.mf_start <= '0;
         if (!sync_n || ph < 0) begin
            // held or lagging: K
            cnt <= sync_n ? cnt + 1 : 0;
            df_lanes.data <= {16{K_CHAR}};
            df_lanes.is_k <= '1;
         end else if (ph < ILAS_CYC) begin
            // lane i marker i cycles late (skew)
            cnt <= cnt + 1;
            df_lanes.data <= {16{(ph / LMFC_PERIOD_CYC == 1) ? Q_CHAR : R_CHAR}};
            for (int i = 0; i < LANES; i++) begin
               df_lanes.mf_start[i] <= (ph % LMFC_PERIOD_CYC) == i;
            end
            if (ph == 40) begin
               df_cfg_valid <= 1'b1;
            end
         end else begin
            // payload, unscrambled like device
            df_lanes.data <= USER;
         end
      end
   end
endmodule
`default_nettype wire

/* sim/jls_link_tb_top.sv */
`default_nettype none
// ==========================================================
// bench top
module jls_link_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import jls_pkg::*;
   localparam logic [127:0] USER = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
   localparam logic [127:0] ADC  = 128'h0F0F_0003_0E0E_0002_0D0D_0001_0C0C_0000;
   logic         mclk = 1'b0;
   logic         rst = 1'b1;
   logic         sysref = 1'b0;
   logic         arm = 1'b0;
   logic [1:0]   rx_sel = 2'h0;
   logic [1:0]   tx_sel = 2'h0;
   logic         fr_req_n = 1'b0;  // held from start
   logic         locked = 1'b0;
   logic         kick = 1'b0;
   jls_cfg_t     cfg_exp = '{8'h03, 8'h01, 1'b0};
   jls_cfg_t     cfg_send = '{8'h03, 8'h01, 1'b0};
   jls_cfg_t     cfg_rx;
   jls_lanes_t   df_lanes;
   jls_lanes_t   fr_lanes;
   logic         cfg_valid, rx_p, rx_m, scaler_reset, divider_reset, oe_n;
   logic         fr_sending_data, dac_valid, mismatch, sync_out_n;
   logic [3:0]   result;
   logic [127:0] dac_samples;
   int           err_count = 0;
   int           checked = 0;
   int           cyc = 0;
   always #2 mclk = ~mclk;
   jls_link_top u_dut (
      .mclk(mclk), .rst(rst), .sysref_pulse_input(sysref), .multichip_sync_arm(arm),
      .realign_on_later_sysref(1'b0), .multichip_sync_result_word(result), .scaler_reset(scaler_reset),
      .divider_reset(divider_reset), .rx_sync_pin_signalling_select(rx_sel),
      .tx_sync_pin_signalling_select(tx_sel), .rx_link_sync_input_p(rx_p), .rx_link_sync_input_m(rx_m),
      .tx_link_sync_output_p(), .tx_link_sync_output_m(), .tx_link_sync_output_m_oe_n(oe_n),
      .adc_samples(ADC), .framer_scramble(1'b0), .fr_lanes(fr_lanes), .fr_sending_data(fr_sending_data),
      .df_lanes(df_lanes), .df_lanes_locked(locked), .df_cfg_expected(cfg_exp), .df_cfg_received(cfg_rx),
      .df_cfg_valid(cfg_valid), .dac_samples(dac_samples), .dac_valid(dac_valid),
      .df_cfg_mismatch(mismatch), .deframer_sync_request_out_n(sync_out_n)
   );
   jls_bbp_model #(.USER(USER)) u_bbp (
      .mclk(mclk), .rst(rst), .sync_n(sync_out_n), .fr_req_n(fr_req_n), .rx_sel(rx_sel), .lag(8'd20),
      .cfg_send(cfg_send), .cfg_kick(kick), .df_lanes(df_lanes), .df_cfg_received(cfg_rx),
      .df_cfg_valid(cfg_valid), .rx_p(rx_p), .rx_m(rx_m)
   );
   // ==========================================================
   // helpers: inputs move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // one sysref pulse, strobes caught
   task automatic pulse(output logic sc, output logic dv);
      sysref = 1'b1;
      tick(1);
      sc = scaler_reset;
      dv = divider_reset;
      sysref = 1'b0;
      tick(1);
      sc |= scaler_reset;
      dv |= divider_reset;
      tick(30);
   endtask
   function automatic logic flag(input int w);
      case (w)
         0: return fr_sending_data;
         1: return sync_out_n;
         2: return dac_valid;
         default: return fr_lanes.is_k != 4'hF;
      endcase
   endfunction
   // bounded wait, n cycles
   task automatic wait_for(input int w, input int lim, output int n);
      n = 0;
      while (n < lim && flag(w) !== 1'b1) begin
         tick(1);
         n++;
      end
   endtask
   task automatic test_done();
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         test_done();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      logic sc;
      logic dv;
      int   n;
      tick(6);
      rst = 1'b0;
      chk("sync_out_n", '0, 128'(sync_out_n));
      tick(1);
      chk("fr is_k", 128'hF, 128'(fr_lanes.is_k));
      tx_sel = 2'h2;
      tick(3);
      chk("oe_n single", 128'h1, 128'(oe_n));
      // release before link sysref: hold CGS
      fr_req_n = 1'b1;
      tick(60);
      chk("cgs hold", 128'hF, 128'(fr_lanes.is_k));
      chk("early data", '0, 128'(fr_sending_data));
      fr_req_n = 1'b0;
      // one unarmed pulse, four armed; three act
      for (int i = 0; i < 5; i++) begin
         arm = (i != 0);
         pulse(sc, dv);
         chk("scaler", 128'(i == 1), 128'(sc));
         chk("divider", 128'(i == 2), 128'(dv));
      end
      chk("status armed", '0, 128'(result));
      arm = 1'b0;
      tick(2);
      chk("status", 128'hB, 128'(result));
      // single-ended release: ILAS at boundary, data
      rx_sel = 2'h1;
      fr_req_n = 1'b1;
      wait_for(3, 40, n);
      chk("ilas start", 128'h1, 128'(n >= 1 && n <= 34));
      chk("mf_start", 128'hF, 128'(fr_lanes.mf_start));
      wait_for(0, 200, n);
      chk("ilas length", 128'h1, 128'(n >= 126 && n <= 130));
      tick(3);
      chk("fr data", ADC, fr_lanes.data);
      chk("data is_k", '0, 128'(fr_lanes.is_k));
      fr_req_n = 1'b0;
      tick(4);
      chk("rereq K", 128'hF, 128'(fr_lanes.is_k));
      // deframer lock, release, payload
      chk("early sync", '0, 128'(sync_out_n));
      locked = 1'b1;
      wait_for(1, 40, n);
      chk("sync release", 128'h1, 128'(n >= 1 && n <= 34));
      wait_for(2, 300, n);
      chk("dac valid", 128'h1, 128'(n < 300));
      tick(200);
      chk("dac data", USER, dac_samples);
      chk("cfg match", '0, 128'(mismatch));
      cfg_send.lanes_m1 = 8'h01;
      kick = 1'b1;
      tick(1);
      kick = 1'b0;
      tick(3);
      chk("cfg mismatch", 128'h1, 128'(mismatch));
      test_done();
   end
endmodule
`default_nettype wire
